// ===== logic/sbsram_consts.svh
`ifndef SBSRAM_CONSTS_SVH
`define SBSRAM_CONSTS_SVH

// Geometry
`define SBSRAM_ADDR_W      18
`define SBSRAM_DATA_W      72
`define SBSRAM_LANES       8
`define SBSRAM_LANE_W      9
`define SBSRAM_BEAT_W      2

// Sleep timing: figures in clock periods
`define SBSRAM_SLEEP_IGNORE_PERIODS 2
`define SBSRAM_SLEEP_EXIT_PERIODS   2

`endif

// ===== logic/sbsram_pkg.sv
package sbsram_pkg;
	typedef enum logic [1:0] {
		SBSRAM_OP_IDLE  = 2'b00,
		SBSRAM_OP_READ  = 2'b01,
		SBSRAM_OP_WRITE = 2'b10
	} sbsram_op_t;

	// Control pins sampled at a clock edge
	typedef struct packed {
		logic       primary_select_n;
		logic       secondary_select_high;
		logic       secondary_select_n;
		logic       load_strobe_proc_n;
		logic       load_strobe_ctrl_n;
		logic       burst_step_n;
		logic       global_write_n;
		logic       byte_write_gate_n;
		logic [7:0] lane_write_n;
	} sbsram_ctrl_t;
endpackage : sbsram_pkg

// ===== logic/sbsram_burst_ctr.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbsram_consts.svh"

// Next beat address inside a four-word group
module sbsram_burst_ctr (
	input  wire logic [1:0] base_i,   // Loaded low address bits
	input  wire logic [1:0] beat_i,   // Beat number to produce
	input  wire logic       linear_i, // High: linear order
	output logic      [1:0] addr_o    // Low address bits for beat
);
	always_comb begin
		if (linear_i) begin
			addr_o = base_i + beat_i;
		end else begin
			addr_o = base_i ^ beat_i;
		end
	end
endmodule : sbsram_burst_ctr

`default_nettype wire

// ===== logic/sbsram_access.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbsram_consts.svh"

module sbsram_access
	import sbsram_pkg::*;
#(
	parameter int ADDR_W = `SBSRAM_ADDR_W,
	parameter int DATA_W = `SBSRAM_DATA_W
) (
	input  wire logic              clk_i,           // Single clock
	input  wire logic              nrst_i,          // Sync reset, low
	input  wire sbsram_pkg::sbsram_ctrl_t ctrl_i,   // Sampled controls
	input  wire logic [ADDR_W-1:0] address_pins_i,  // External address
	input  wire logic              burst_linear_i,  // Order pin, low=linear
	input  wire logic              output_enable_n_i, // Output enable, low
	input  wire logic              sleep_request_i, // Sleep, high active
	input  wire logic [DATA_W-1:0] dq_i,            // Data pins in
	output logic      [DATA_W-1:0] dq_o,            // Data pins out
	output logic      [DATA_W-1:0] dq_oe_o,         // High while driving
	output logic                   sleeping_o,      // In sleep mode
	output logic                   busy_o           // Burst in progress
);
	import sbsram_pkg::*;

	localparam int LANES  = `SBSRAM_LANES;
	localparam int LANE_W = `SBSRAM_LANE_W;
	localparam int DEPTH  = 1 << ADDR_W;
	localparam logic [1:0] SLEEP_IGN  = 2'(`SBSRAM_SLEEP_IGNORE_PERIODS);
	localparam logic [1:0] SLEEP_EXIT = 2'(`SBSRAM_SLEEP_EXIT_PERIODS);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_write(input sbsram_ctrl_t c);
		return !c.global_write_n ||
			(!c.byte_write_gate_n && (c.lane_write_n != 8'hFF));
	endfunction : is_write

	function automatic logic [LANES-1:0] lane_mask(input sbsram_ctrl_t c);
		if (!c.global_write_n) begin
			return {LANES{1'b1}};
		end
		if (!c.byte_write_gate_n) begin
			return ~c.lane_write_n;
		end
		return '0;
	endfunction : lane_mask

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [DEPTH];

	// ----------------------------------------------------------------
	// Sleep handling
	// ----------------------------------------------------------------
	// Sleep takes effect combinationally on the pins; the counter
	// keeps inputs ignored for two edges after it falls.
	logic [1:0] sleep_hold;
	logic [1:0] next_sleep_hold;
	logic       gated;

	always_comb begin
		if (sleep_request_i) begin
			next_sleep_hold = SLEEP_EXIT;
		end else if (sleep_hold != 2'h0) begin
			next_sleep_hold = sleep_hold - 2'h1;
		end else begin
			next_sleep_hold = 2'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sleep_hold <= 2'h0;
		end else begin
			sleep_hold <= next_sleep_hold;
		end
	end

	assign gated = sleep_request_i || (sleep_hold != 2'h0);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic selected;
	logic proc_load;
	logic ctrl_load;
	logic any_load;

	assign selected = !ctrl_i.primary_select_n &&
		ctrl_i.secondary_select_high && !ctrl_i.secondary_select_n;
	// Processor strobe has no effect while primary select is high
	assign proc_load = !ctrl_i.load_strobe_proc_n &&
		!ctrl_i.primary_select_n;
	assign ctrl_load = !ctrl_i.load_strobe_ctrl_n;
	assign any_load  = proc_load || ctrl_load;

	// ----------------------------------------------------------------
	// Burst state
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] base_addr;
	logic [1:0]        beat;
	logic              active;
	logic [ADDR_W-1:0] next_base_addr;
	logic [1:0]        next_beat;
	logic              next_active;
	logic [1:0]        step_low;
	sbsram_op_t        op;

	sbsram_burst_ctr u_ctr (
		.base_i   (base_addr[1:0]),
		.beat_i   (beat + 2'h1),
		.linear_i (!burst_linear_i),
		.addr_o   (step_low)
	);

	// Address used by this edge's access
	logic [ADDR_W-1:0] acc_addr;
	logic [1:0]        acc_low;

	always_comb begin
		next_base_addr = base_addr;
		next_beat      = beat;
		next_active    = active;
		op             = SBSRAM_OP_IDLE;
		acc_low        = 2'h0;
		acc_addr       = base_addr;
		if (gated) begin
			op = SBSRAM_OP_IDLE;
		end else if (any_load && !selected) begin
			next_active = 1'b0;
		end else if (proc_load) begin
			next_base_addr = address_pins_i;
			next_beat      = 2'h0;
			next_active    = 1'b1;
			acc_addr       = address_pins_i;
			op             = SBSRAM_OP_READ;
		end else if (ctrl_load) begin
			next_base_addr = address_pins_i;
			next_beat      = 2'h0;
			next_active    = 1'b1;
			acc_addr       = address_pins_i;
			op = is_write(ctrl_i) ? SBSRAM_OP_WRITE
				: SBSRAM_OP_READ;
		end else if (active) begin
			if (!ctrl_i.burst_step_n) begin
				next_beat = beat + 2'h1;
				acc_low   = step_low;
			end else begin
				acc_low = (burst_linear_i) ? (base_addr[1:0] ^ beat)
					: (base_addr[1:0] + beat);
			end
			// Upper bits stay at the loaded value
			acc_addr = {base_addr[ADDR_W-1:2], acc_low};
			op = is_write(ctrl_i) ? SBSRAM_OP_WRITE
				: SBSRAM_OP_READ;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			base_addr <= '0;
			beat      <= 2'h0;
			active    <= 1'b0;
		end else begin
			base_addr <= next_base_addr;
			beat      <= next_beat;
			active    <= next_active;
		end
	end

	// ----------------------------------------------------------------
	// Array access and output stage
	// ----------------------------------------------------------------
	// Writes complete inside the edge; no strobe from outside needed.
	logic [LANES-1:0] wmask;
	assign wmask = lane_mask(ctrl_i);

	always_ff @(posedge clk_i) begin
		if (op == SBSRAM_OP_WRITE) begin
			for (int l = 0; l < LANES; l++) begin
				if (wmask[l]) begin
					mem[acc_addr][l*LANE_W +: LANE_W] <=
						dq_i[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	logic [DATA_W-1:0] rd_data;
	logic              rd_valid;
	logic [DATA_W-1:0] next_rd_data;
	logic              next_rd_valid;

	always_comb begin
		next_rd_data  = rd_data;
		next_rd_valid = (op == SBSRAM_OP_READ);
		if (op == SBSRAM_OP_READ) begin
			next_rd_data = mem[acc_addr];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rd_data  <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	// Pin drivers: registered, but output enable and sleep must cut
	// the drive without a clock, so the enable register is qualified.
	logic drive_q;
	logic next_drive_q;
	logic sleep_q;
	logic busy_q;

	always_comb begin
		next_drive_q = rd_valid && !gated;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			drive_q <= 1'b0;
			sleep_q <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			drive_q <= next_drive_q;
			sleep_q <= gated;
			busy_q  <= next_active;
		end
	end

	// out_q holds the data one more stage but is unused; dq_o takes rd_data, in step with rd_valid.
	logic [DATA_W-1:0] out_q;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			out_q <= '0;
		end else begin
			out_q <= rd_valid ? rd_data : out_q;
		end
	end

	always_comb begin
		dq_o    = rd_data;
		dq_oe_o = {DATA_W{rd_valid && !output_enable_n_i &&
			!sleep_request_i}};
	end

	assign sleeping_o = sleep_q;
	assign busy_o     = busy_q;
endmodule : sbsram_access

`default_nettype wire

// ===== verif/sbsram_access_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module sbsram_access_chk
	import sbsram_pkg::*;
#(
	parameter int DATA_W = 72
) (
	input wire logic                     clk_i,             // Clock
	input wire logic                     nrst_i,            // Reset, low
	input wire sbsram_pkg::sbsram_ctrl_t ctrl_i,            // Controls
	input wire logic                     output_enable_n_i, // OE, low
	input wire logic                     sleep_request_i,   // Sleep
	input wire logic [DATA_W-1:0]        dq_oe_o,           // Drive
	input wire logic                     sleeping_o,        // Asleep
	input wire logic                     busy_o             // Burst
);
	logic sel;
	logic go;
	assign sel = !ctrl_i.primary_select_n && ctrl_i.secondary_select_high
		&& !ctrl_i.secondary_select_n;
	// Exit hold counts as asleep, so commands then prove nothing
	assign go = !sleeping_o && !sleep_request_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_sleep_floats: assert property (
		sleep_request_i |-> dq_oe_o == '0) else $error("driven in sleep");
	a_oe_blocks: assert property (
		output_enable_n_i |-> dq_oe_o == '0) else $error("driven, oe high");
	a_read_answer: assert property (
		go && sel && !ctrl_i.load_strobe_proc_n |=> busy_o
		&& (output_enable_n_i || sleep_request_i || &dq_oe_o))
		else $error("read not answered");
	a_write_quiet: assert property (
		go && sel && ctrl_i.load_strobe_proc_n && !ctrl_i.load_strobe_ctrl_n
		&& !ctrl_i.global_write_n |=> dq_oe_o == '0)
		else $error("write drove pins");
	a_deselect: assert property (
		go && ctrl_i.primary_select_n && !ctrl_i.load_strobe_ctrl_n
		|=> !busy_o && dq_oe_o == '0) else $error("deselect failed");
	a_reset_quiet: assert property (disable iff (1'b0)
		!nrst_i |=> dq_oe_o == '0 && !busy_o && !sleeping_o)
		else $error("not quiet after reset");
	a_sleep_enter: assert property (
		sleep_request_i |=> sleeping_o) else $error("sleep not entered");
	a_exit_hold: assert property (
		$fell(sleep_request_i) |-> sleeping_o [*2])
		else $error("exit hold too short");
endmodule : sbsram_access_chk

bind sbsram_access sbsram_access_chk #(.DATA_W(DATA_W)) u_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .ctrl_i(ctrl_i),
	.output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
	.dq_oe_o(dq_oe_o), .sleeping_o(sleeping_o), .busy_o(busy_o));
`default_nettype wire

// ===== verif/sbsram_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Memory controller model
// ------------------------------
module sbsram_ctl_model
	import sbsram_pkg::*;
(
	input  wire logic                    clk_i,  // Clock
	output var sbsram_pkg::sbsram_ctrl_t ctrl_o, // Controls
	output logic [17:0]                  addr_o, // Address
	output logic [71:0]                  dq_o,   // Write data
	output logic                         oe_n_o, // Output enable
	output logic                         sleep_o // Sleep request
);
	initial begin
		ctrl_o = 16'hFFFF;
		addr_o = 18'h00000;
		dq_o = 72'h0;
		oe_n_o = 1'b1;
		sleep_o = 1'b0;
	end
	// Unused pins flip each cycle so stale values never pass for good ones
	task automatic cyc(input logic sel, ps, cs, adv, gw,
		input logic [7:0] lanes, input logic [17:0] a,
		input logic [71:0] d, input logic oe);
		logic wr;
		wr = ps && (!gw || lanes != 8'hFF);
		@(posedge clk_i);
		ctrl_o <= {!sel, 1'b1, 1'b0, ps, cs, adv, gw, 1'b0, lanes};
		addr_o <= (ps && cs) ? ~addr_o : a;
		dq_o <= wr ? d : ~dq_o;
		oe_n_o <= wr | oe;
	endtask : cyc
	task automatic snooze(input int n);
		@(posedge clk_i);
		ctrl_o <= 16'hFFFF;
		sleep_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		sleep_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : snooze
endmodule : sbsram_ctl_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sbsram_pkg::*;
	logic         clk_i, nrst_i, lin, oe_n, sleep, sleeping_o, busy_o;
	sbsram_ctrl_t ctrl;
	logic [17:0]  addr;
	logic [71:0]  wdata, dq_o, dq_oe_o;
	int           miscompares, compares;
	sbsram_ctl_model ctl (.clk_i(clk_i), .ctrl_o(ctrl), .addr_o(addr),
		.dq_o(wdata), .oe_n_o(oe_n), .sleep_o(sleep));
	sbsram_access DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ctrl_i(ctrl),
		.address_pins_i(addr), .burst_linear_i(lin),
		.output_enable_n_i(oe_n), .sleep_request_i(sleep), .dq_i(wdata),
		.dq_o(dq_o), .dq_oe_o(dq_oe_o), .sleeping_o(sleeping_o),
		.busy_o(busy_o));
	// ------------------------------
	// Checks and scenarios
	// ------------------------------
	task automatic chk(input string what, input logic [71:0] exp, got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic look(input logic [71:0] exp);
		@(negedge clk_i);
		chk("dq", exp, dq_o);
		chk("oe", '1, dq_oe_o);
	endtask : look
	task automatic t_bursts();
		logic [17:0] b;
		logic [1:0]  k;
		b = 18'h2ACDC;
		// Step held high on the load write; the load ignores it and lands at the loaded word
		for (int n = 0; n < 4; n++)
			ctl.cyc(1, 1, n != 0, n == 0, 0, 8'hFF, b, {4{b + 18'(n)}},
				0);
		for (int m = 0; m < 8; m++) begin
			lin <= m[2];
			ctl.cyc(1, 0, 1, 0, 0, 8'h00, b + 18'(m[1:0]), '0, 0);
			for (int n = 1; n < 6; n++) begin
				ctl.cyc(1, 1, 1, n > 3, 1, 8'hFF, b, '0, 0);
				k = (n > 4) ? 2'h3 : 2'(n - 1);
				k = lin ? (m[1:0] ^ k) : (m[1:0] + k);
				look({4{b[17:2], k}});
			end
		end
	endtask : t_bursts
	task automatic t_lanes();
		logic [71:0] e;
		e = '0;
		ctl.cyc(1, 1, 0, 0, 0, 8'hFF, 18'h15A5A, '0, 0);
		for (int k = 0; k < 9; k++) begin
			ctl.cyc(1, 1, 0, 0, 1, k ? ~(8'h01 << (k - 1)) : 8'hFF, 18'h15A5A,
				'1, 0);
			if (k > 0)
				e |= 72'h1FF << (9 * (k - 1));
			ctl.cyc(1, 0, 1, 0, 1, 8'hFF, 18'h15A5A, '0, 0);
			ctl.cyc(1, 1, 1, 1, 1, 8'hFF, 18'h0, '0, 0);
			look(e);
		end
	endtask : t_lanes
	task automatic t_float();
		ctl.cyc(1, 0, 1, 0, 1, 8'hFF, 18'h15A5A, '0, 1);
		ctl.cyc(1, 1, 1, 1, 1, 8'hFF, 18'h0, '0, 1);
		@(negedge clk_i);
		chk("oe", '0, dq_oe_o);
		ctl.cyc(0, 1, 0, 0, 1, 8'hFF, 18'h15A5A, '0, 0);
		ctl.cyc(0, 1, 0, 0, 1, 8'hFF, 18'h15A5A, '0, 0);
		@(negedge clk_i);
		chk("busy", '0, busy_o);
		chk("oe", '0, dq_oe_o);
		fork
			ctl.snooze(4);
			begin
				repeat (3) @(negedge clk_i);
				chk("sleeping", 1, sleeping_o);
				chk("oe", '0, dq_oe_o);
			end
		join
		ctl.cyc(1, 0, 1, 0, 1, 8'hFF, 18'h15A5A, '0, 0);
		ctl.cyc(1, 1, 1, 1, 1, 8'hFF, 18'h0, '0, 0);
		look('1);
	endtask : t_float
	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		nrst_i = 1'b0;
		lin = 1'b1;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		chk("oe", '0, dq_oe_o);
		t_bursts();
		t_lanes();
		t_float();
		final_report();
	end
	// Whole run is some 100 cycles
	initial begin
		#20000;
		miscompares++;
		final_report();
	end
endmodule : tb
`default_nettype wire
